// ===== sar_comparator.sv
`timescale 1ns/100ps
// ****
// Comparator model
// ****
module sar_comparator (
	// Analog side
	input wire logic [7:0] target,
	// Ladder and comparator
	input wire logic [7:0] ladder,
	output logic data_in
);
	// Lower bits stay high during a trial, so the trial bit is kept only when the input is above the ladder.
	assign data_in = target > ladder;
endmodule : sar_comparator

// ===== sar_map.svh
`ifndef SAR_MAP_SVH
`define SAR_MAP_SVH
// ****************************************
// Widths and reset values
// ****************************************
`define SAR_NARROW_BITS 8
`define SAR_WIDE_BITS 12
`define SAR_DONE_RESET 1'h0
`endif

// ===== sar_master.sv
`timescale 1ns/100ps
// ****************************************
// Control element of one trial bit
// ****************************************
module sar_master (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Token path
	input wire logic token_in,
	input wire logic load,
	input wire logic init,
	output logic token_q
);
	logic token_d;
	always_comb begin
		token_d = token_q;
		if (init) begin
			token_d = 1'b0;
		end else if (load) begin
			token_d = token_in;
		end
	end
	// Register clock low phase is modelled as the update before the rising edge.
	always_ff @(posedge clk) begin // see RULE_02
		if (!resetn) begin
			token_q <= 1'b0;
		end else begin
			token_q <= token_d;
		end
	end
endmodule : sar_master

// ===== sar_pkg.sv
package sar_pkg;
	typedef enum logic {
		SAR_START_STOP,
		SAR_CONTINUOUS
	} sar_mode_t;
	typedef struct packed {
		logic start_n;
		logic data_in;
		logic enable_n;
	} sar_ctl_t;
endpackage : sar_pkg

// ===== sar_register.sv
`timescale 1ns/100ps
`include "sar_map.svh"
// Functional notes
// RULE_01 - The register is built at 8 or 12 result bits, each holding all control and storage for a conversion.
// RULE_02 - Control elements update only in the phase leading up to the clock edge.
// RULE_03 - Result bits change only on the rising clock edge and hold otherwise.
// RULE_04 - Each rising edge stores the serial data input into the trial bit and shows it on the parallel and serial outputs.
// RULE_05 - The same edge drives the next less significant bit low as the next trial bit.
// RULE_06 - Start-stop mode halts after each conversion and continuous mode restarts at once.
// RULE_07 - A cascade input and output extend the register and a length select truncates it.
// RULE_08 - Sequencing uses only the token chain, so the block also works as shifter or ring counter.
// RULE_09 - Conversion done is high during conversion and low once it has finished.
// RULE_10 - A low start sets the top bit low, all other bits high and deasserts completion; the last bit trial ends it.
module sar_register #(
	parameter int WIDTH = `SAR_WIDE_BITS
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Control
	input wire sar_pkg::sar_ctl_t ctl,
	input wire sar_pkg::sar_mode_t mode,
	input wire logic [3:0] last_bit,
	// Cascade
	input wire logic cascade_in,
	output logic cascade_out,
	// Results
	output logic [WIDTH-1:0] result_q,
	output logic top_result_bit,
	output logic top_result_bit_n,
	output logic serial_out_q,
	output logic conversion_done_n
);
	// ****************************************
	// Token chain
	// ****************************************
	logic [WIDTH-1:0] token;
	logic [WIDTH-1:0] result_d;
	logic done_q;
	logic done_d;
	logic serial_d;
	logic start;
	logic restart;
	logic [WIDTH:0] chain;
	assign restart = (mode == sar_pkg::SAR_CONTINUOUS) && done_q;
	assign start = !ctl.start_n || restart; // see RULE_06
	assign chain[WIDTH] = start;
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit // see RULE_01
			// Truncation only raises done; in start-stop mode the token chain runs on to bit 0 and no analog feedback steers it.
			sar_master u_master (
				.clk(clk),
				.resetn(resetn),
				.token_in(chain[i+1]),
				.load(1'b1),
				.init(start && (i != WIDTH-1)),
				.token_q(token[i])
			); // see RULE_08
			// A start flushes every lower token, so a restart never leaves a stale trial behind.
			assign chain[i] = token[i] && !start; // see RULE_05
		end
	endgenerate
	assign cascade_out = token[0];

	// ****************************************
	// Trial bookkeeping
	// ****************************************
	// The trial counter only feeds the checks below; five flops buy a direct check of conversion length.
	localparam logic [4:0] FULL_TRIALS = 5'(WIDTH);
	logic [4:0] trials_q;
	logic [4:0] trials_d;

	function automatic logic [3:0] trial_index(input logic [WIDTH-1:0] t);
		logic [3:0] idx;
		idx = 4'h0;
		for (int k = 0; k < WIDTH; k++) begin
			if (t[k]) begin
				idx = 4'(k);
			end
		end
		return idx;
	endfunction : trial_index

	always_comb begin
		trials_d = trials_q;
		if (start) begin
			trials_d = 5'h0;
		end else if (token != '0) begin
			trials_d = trials_q + 5'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			trials_q <= 5'h0;
		end else begin
			trials_q <= trials_d;
		end
	end

	// ****************************************
	// Result slaves
	// ****************************************
	always_comb begin
		result_d = result_q;
		serial_d = serial_out_q;
		done_d = done_q;
		if (start) begin
			result_d = {1'b0, {(WIDTH-1){1'b1}}}; // see RULE_10
			done_d = 1'b0;
		end else begin
			for (int b = 0; b < WIDTH; b++) begin
				if (token[b]) begin
					result_d[b] = ctl.data_in; // see RULE_04
					serial_d = ctl.data_in;
					if (b > 0) begin
						result_d[b-1] = 1'b0; // see RULE_05
					end
					if (b[3:0] == last_bit || b == 0) begin
						done_d = 1'b1; // see RULE_07
					end
				end
			end
			if (cascade_in && !done_q) begin
				done_d = 1'b0;
			end
		end
	end
	always_ff @(posedge clk) begin // see RULE_03
		if (!resetn) begin
			result_q <= '1;
			serial_out_q <= 1'b0;
			done_q <= `SAR_DONE_RESET;
		end else begin
			result_q <= result_d;
			serial_out_q <= serial_d;
			done_q <= done_d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign conversion_done_n = !done_q; // see RULE_09
	assign top_result_bit = ctl.enable_n ? 1'b1 : result_q[WIDTH-1];
	assign top_result_bit_n = !result_q[WIDTH-1];

	// ****************************************
	// Checks
	// ****************************************
	done_until_start_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE_09
		!ctl.start_n |=> conversion_done_n)
		else $error("done not cleared by start");
	start_pattern_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE_10
		!ctl.start_n |=> result_q[WIDTH-1] == 1'b0)
		else $error("start pattern wrong");
	first_trial_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE_04
		!ctl.start_n |=> token[WIDTH-1])
		else $error("trial missed");
	hold_result_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE_03
		(token == '0 && ctl.start_n && !restart) |=> $stable(result_q))
		else $error("result changed without trial");
	next_low_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE_05
		(token[1] && !start) |=> result_q[0] == 1'b0)
		else $error("next bit not low");
	store_data_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE_04
		(token[WIDTH-1] && !start) |=> result_q[WIDTH-1] == $past(ctl.data_in))
		else $error("data not stored");
	serial_copy_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE_04
		(token != '0 && !start) |=> serial_out_q == $past(ctl.data_in))
		else $error("serial out wrong");
	cont_restart_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE_06
		(mode == sar_pkg::SAR_CONTINUOUS && done_q) |=> !done_q)
		else $error("no restart");
	one_token_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE_08
		$onehot0(token))
		else $error("more than one trial token");
	step_down_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE_08
		(token != '0 && !token[0] && !start) |=> trial_index(token) == $past(trial_index(token)) - 4'h1)
		else $error("token did not step down");
	conv_length_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE_01
		($rose(done_q) && last_bit == 4'h0) |-> trials_q == FULL_TRIALS)
		else $error("wrong number of trials");
	done_hold_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE_09
		(done_q && ctl.start_n && !restart) |=> done_q)
		else $error("done dropped without start");
	chain_empty_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE_09
		(done_q && last_bit == 4'h0) |-> token == '0)
		else $error("trial running while done");
	start_tokens_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE_10
		!ctl.start_n |=> token == {1'b1, {(WIDTH-1){1'b0}}})
		else $error("start token wrong");
	start_low_bits_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE_10
		!ctl.start_n |=> result_q[WIDTH-2:0] == '1)
		else $error("start low bits wrong");
	serial_idle_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE_03
		(token == '0 && !start) |=> $stable(serial_out_q))
		else $error("serial changed without trial");
	trial_last_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE_09
		(token[0] && !start && !cascade_in) |=> done_q)
		else $error("last trial did not finish");
	trunc_done_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE_07
		(token != '0 && trial_index(token) == last_bit && last_bit != 4'h0 && !start && !cascade_in) |=> done_q)
		else $error("truncated trial did not finish");
	cascade_done_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE_07
		(cascade_in && !done_q && !start) |=> !done_q)
		else $error("cascade did not hold done");
	cont_token_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE_06
		(mode == sar_pkg::SAR_CONTINUOUS && done_q) |=> token[WIDTH-1])
		else $error("continuous restart token missing");

	// ****************************************
	// Coverage
	// ****************************************
	conv_start_c: cover property (@(posedge clk) disable iff (!resetn) !ctl.start_n);
	conv_done_c: cover property (@(posedge clk) disable iff (!resetn) $fell(conversion_done_n));
	cont_mode_c: cover property (@(posedge clk) disable iff (!resetn) restart);
	trunc_done_c: cover property (@(posedge clk) disable iff (!resetn) $rose(done_q) && last_bit != 4'h0);
	full_done_c: cover property (@(posedge clk) disable iff (!resetn) $rose(done_q) && last_bit == 4'h0);
endmodule : sar_register

// ===== test_successive_approx_register.sv
`timescale 1ns/100ps
// ****
// Bench
// ****
module test_successive_approx_register;
	logic clk = 1'h0;
	logic resetn = 1'h0;
	logic start_n = 1'h1;
	logic enable_n = 1'h0;
	logic data_in;
	logic done_prev = 1'h1;
	logic top_result_bit, top_result_bit_n, serial_out_q, conversion_done_n;
	logic [7:0] target = 8'h00;
	logic [7:0] result_q;
	logic [8:0] exp_q[$];
	logic cascade_out;
	logic [3:0] last_bit = 4'h0;
	logic [7:0] corners[5] = '{8'h00, 8'hff, 8'h80, 8'h7f, 8'h01};
	sar_pkg::sar_ctl_t ctl;
	sar_pkg::sar_mode_t mode = sar_pkg::SAR_START_STOP;
	int n_errors = 0;
	int compares = 0;
	int cycles = 0;
	int dones = 0;
	int seed = 32'h7d12c8b5;
	assign ctl = {start_n, data_in, enable_n};
	sar_register #(.WIDTH(8)) dut (.clk(clk), .resetn(resetn), .ctl(ctl), .mode(mode), .last_bit(last_bit),
		.cascade_in(1'h0), .cascade_out(cascade_out), .result_q(result_q), .top_result_bit(top_result_bit),
		.top_result_bit_n(top_result_bit_n), .serial_out_q(serial_out_q), .conversion_done_n(conversion_done_n));
	sar_comparator cmp (.target(target), .ladder(result_q), .data_in(data_in));
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic report_and_stop;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : report_and_stop
	task automatic wait_dones(input int n);
		for (int i = 0; i < 30 && dones < n; i++) begin
			@(posedge clk);
			#1;
		end
	endtask : wait_dones
	// The start is held for one edge only, so a second start cannot hide a stuck conversion.
	task automatic convert(input logic [7:0] t, input int n);
		logic [7:0] e;
		e = t;
		for (int k = 0; k < 8; k++) begin
			if (k < int'(last_bit)) begin
				e[k] = (k == int'(last_bit) - 1) ? 1'b0 : 1'b1;
			end
		end
		target = t;
		start_n = 1'h0;
		repeat (n) exp_q.push_back({t[last_bit], e});
		@(posedge clk);
		#1;
		start_n = 1'h1;
		check("start", result_q, 8'h7f);
		check("cascade", {7'h0, cascade_out}, 8'h00);
		check("busy", {7'h0, conversion_done_n}, 8'h01);
	endtask : convert
	initial begin
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		#1;
		enable_n = 1'($random(seed));
	end
	always @(posedge clk) begin
		#2;
		cycles++;
		if (cycles > 3000) begin
			n_errors++;
			report_and_stop();
		end else begin
			check("top", {7'h0, top_result_bit}, {7'h0, enable_n | result_q[7]});
			check("top_n", {7'h0, top_result_bit_n}, {7'h0, ~result_q[7]});
			if (resetn && done_prev && !conversion_done_n) begin
				dones++;
				if (exp_q.size() == 0) begin
					check("extra", 8'h01, 8'h00);
				end else begin
					check("result", result_q, exp_q[0][7:0]);
					check("serial", {7'h0, serial_out_q}, {7'h0, exp_q[0][8]});
					void'(exp_q.pop_front());
				end
			end
			done_prev = conversion_done_n;
		end
	end
	initial begin
		repeat (2) @(posedge clk);
		#1;
		resetn = 1'h1;
		check("reset", result_q, 8'hff);
		foreach (corners[i]) begin
			convert(corners[i], 1);
			wait_dones(dones + 1);
		end
		repeat (6) begin
			convert(8'($random(seed)), 1);
			wait_dones(dones + 1);
		end
		mode = sar_pkg::SAR_CONTINUOUS;
		convert(8'h5a, 3);
		wait_dones(dones + 2);
		mode = sar_pkg::SAR_START_STOP;
		wait_dones(dones + 1);
		last_bit = 4'h4;
		convert(8'h9c, 1);
		wait_dones(dones + 1);
		repeat (6) @(posedge clk);
		#1;
		last_bit = 4'h0;
		repeat (12) @(posedge clk);
		check("pending", 8'(exp_q.size()), 8'h00);
		report_and_stop();
	end
endmodule : test_successive_approx_register
